// File: logic/dmsr_pkg.sv
// constants and carrier types for the drive monitor status register bank
package dmsr_pkg;

  // register numbers on the serial register port
  localparam logic [15:0] ADDR_LINK_STATUS  = 16'h0022; // data-link status
  localparam logic [15:0] ADDR_FREQ_REF     = 16'h0023; // frequency ref mirror
  localparam logic [15:0] ADDR_OUT_FREQ     = 16'h0024; // output frequency
  localparam logic [15:0] ADDR_OUT_VOLT     = 16'h0025; // output voltage ref
  localparam logic [15:0] ADDR_OUT_CURR     = 16'h0026; // output current
  localparam logic [15:0] ADDR_OUT_POWER    = 16'h0027; // output power
  localparam logic [15:0] ADDR_TORQUE_REF   = 16'h0028; // torque reference
  localparam logic [15:0] ADDR_INPUT_TERMS  = 16'h002b; // input terminals
  localparam logic [15:0] ADDR_DRIVE_FLAGS  = 16'h002c; // drive condition
  localparam logic [15:0] ADDR_OUTPUT_TERMS = 16'h002d; // output terminals
  localparam logic [15:0] ADDR_DC_BUS       = 16'h0031; // dc bus voltage
  localparam logic [15:0] ADDR_PID_FB       = 16'h0038; // pid feedback
  localparam logic [15:0] ADDR_PID_IN       = 16'h0039; // pid input
  localparam logic [15:0] ADDR_PID_OUT      = 16'h003a; // pid output
  localparam logic [15:0] ADDR_MAIN_FW      = 16'h003b; // main firmware no.
  localparam logic [15:0] ADDR_FLASH_FW     = 16'h003c; // flash firmware no.
  localparam logic [15:0] ADDR_LINK_ERRORS  = 16'h003d; // link error details

  // data-link status bit positions
  localparam int LINK_BUSY_BIT      = 0;  // written data being processed
  localparam int LINK_LIMIT_BIT     = 3;  // upper or lower limit error
  localparam int LINK_INTEGRITY_BIT = 4;  // data integrity error

  // drive condition bit positions
  localparam int DRV_RUNNING_BIT    = 0;  // operating
  localparam int DRV_ZERO_SPD_BIT   = 1;  // zero speed
  localparam int DRV_FREQ_MATCH_BIT = 2;  // frequency matched
  localparam int DRV_USER_SPD_BIT   = 3;  // user speed matched
  localparam int DRV_FDET_LE_BIT    = 4;  // out freq at or below level
  localparam int DRV_FDET_GE_BIT    = 5;  // out freq at or above level
  localparam int DRV_STARTUP_BIT    = 6;  // startup completed
  localparam int DRV_LOW_VOLT_BIT   = 7;  // low voltage detected
  localparam int DRV_BASEBLOCK_BIT  = 8;  // output baseblocked
  localparam int DRV_REF_SRC_BIT    = 9;  // freq ref not from link
  localparam int DRV_RUN_SRC_BIT    = 10; // run command not from link
  localparam int DRV_OVERTORQ_BIT   = 11; // overtorque detected
  localparam int DRV_REF_LOST_BIT   = 12; // frequency reference lost
  localparam int DRV_RETRY_BIT      = 13; // retrying after fault
  localparam int DRV_FAULT_BIT      = 14; // fault, time-out included
  localparam int DRV_TIMEOUT_BIT    = 15; // link time-out seen

  // link error detail bit positions
  localparam int ERR_CRC_BIT        = 0;  // crc error
  localparam int ERR_LENGTH_BIT     = 1;  // invalid data length
  localparam int ERR_PARITY_BIT     = 3;  // parity error
  localparam int ERR_OVERRUN_BIT    = 4;  // overrun error
  localparam int ERR_FRAMING_BIT    = 5;  // framing error
  localparam int ERR_TIMEOUT_BIT    = 6;  // time-out

  // terminal widths and synchroniser width
  localparam int IN_TERMS  = 7;            // multi-function inputs
  localparam int OUT_TERMS = 3;            // contact and photocoupler outs
  localparam int SYNC_W    = IN_TERMS + OUT_TERMS; // pins synchronised

  // values after reset
  localparam logic [15:0] WORD_RESET = 16'h0000; // every held word
  localparam logic [5:0]  ERR_RESET  = 6'h00;    // sticky error flags

  // level flags from the drive's own control logic
  typedef struct packed {
    logic running;          // motor operating
    logic zero_speed;       // at zero speed
    logic freq_match;       // frequency matched
    logic user_speed_match; // user-defined speed matched
    logic startup_done;     // startup completed
    logic low_voltage;      // low voltage detected
    logic baseblock;        // output baseblocked
    logic ref_not_link;     // freq reference from another source
    logic run_not_link;     // run command from another source
    logic overtorque;       // overtorque detected
    logic ref_lost;         // frequency reference lost
    logic retrying;         // retrying after fault
    logic fault;            // any drive fault
  } dmsr_drive_flags_t;

  // measurement values mirrored from the drive
  typedef struct packed {
    logic [15:0] freq_ref;   // frequency reference item
    logic [15:0] out_freq;   // output frequency item
    logic [15:0] out_volt;   // output voltage item
    logic [15:0] out_curr;   // output current item
    logic [15:0] out_power;  // output power item
    logic [15:0] torque_ref; // torque reference item
    logic [15:0] dc_bus;     // dc bus voltage
    logic [15:0] pid_fb;     // unsigned, ten counts per percent
    logic [15:0] pid_in;     // signed, ten counts per percent
    logic [15:0] pid_out;    // signed, ten counts per percent
    logic [15:0] main_fw;    // main firmware number
    logic [15:0] flash_fw;   // flash firmware number
  } dmsr_monitor_t;

  // one-cycle link error events from the receiver
  typedef struct packed {
    logic timeout;    // time-out
    logic framing;    // framing error
    logic overrun;    // overrun error
    logic parity;     // parity error
    logic bad_length; // invalid data length
    logic crc;        // crc error
  } dmsr_link_err_t;

endpackage

// File: logic/dmsr_pin_sync.sv
// two-flop synchroniser for the terminal pin levels
`timescale 1ns/1ps
module dmsr_pin_sync (
  input  wire logic                      sys_clk_in,  // system clock
  input  wire logic                      reset_in,    // sync reset, high
  input  wire logic [dmsr_pkg::SYNC_W-1:0] pins_in,   // raw pin levels
  output logic      [dmsr_pkg::SYNC_W-1:0] pins_out   // synchronised
);

  logic [dmsr_pkg::SYNC_W-1:0] stage_one; // metastable stage, no taps

  // first stage is read only by the second
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      stage_one <= '0;
      pins_out  <= '0;
    end else begin
      stage_one <= pins_in;
      pins_out  <= stage_one;
    end
  end

endmodule

// File: logic/dmsr_bank.sv
// read-only drive monitor status register bank
//
// Summary of operation
// - link status: busy, limit, integrity bits
// - input terminals one to seven in bits 0-6
// - drive status word reports run and state flags
// - bits 4/5: out freq vs detection level
// - bit 7 high while low voltage seen
// - bits 9/A: zero means serial link source
// - bit E fault, time-out counts as fault
// - bit F set once link time-out seen
// - output terminals in bits 0-2, rest zero
// - pid feedback unsigned, ten counts per percent
// - pid input/output signed, ten per percent
// - all registers read-only, writes rejected
// - link errors latch until error reset
`timescale 1ns/1ps
module dmsr_bank (
  input  wire logic                       sys_clk_in,     // 50 MHz clock
  input  wire logic                       reset_in,       // sync reset, high
  input  wire logic [dmsr_pkg::IN_TERMS-1:0]  input_terms_in,  // input pins
  input  wire logic [dmsr_pkg::OUT_TERMS-1:0] output_terms_in, // output pins
  input  wire dmsr_pkg::dmsr_drive_flags_t drive_flags_in, // drive levels
  input  wire dmsr_pkg::dmsr_monitor_t     monitor_in,     // mirrored values
  input  wire logic [15:0]                freq_level_in,  // detection level
  input  wire logic                       write_busy_in,  // write in progress
  input  wire logic                       limit_err_in,   // limit violation
  input  wire logic                       integrity_err_in, // integrity fail
  input  wire dmsr_pkg::dmsr_link_err_t    link_err_in,    // error pulses
  input  wire logic                       error_reset_in, // clear pulse
  input  wire logic                       frame_active_in, // read frame busy
  input  wire logic                       rd_req_in,      // read strobe
  input  wire logic                       wr_req_in,      // write strobe
  input  wire logic [15:0]                addr_in,        // register number
  output logic                            rsp_valid_out,  // answer pulse
  output logic                            rsp_err_out,    // refused access
  output logic [15:0]                     rdata_out       // read data
);

  logic [dmsr_pkg::SYNC_W-1:0] pins_sync;   // synchronised terminal levels
  logic [5:0]  err_sticky;                  // latched link error flags
  logic [5:0]  next_err_sticky;             // next latched flags
  logic        timeout_seen;                // latched time-out for bit F
  logic [15:0] live_link;                   // live data-link word
  logic [15:0] live_in_terms;               // live input terminal word
  logic [15:0] live_drive;                  // live drive condition word
  logic [15:0] live_out_terms;              // live output terminal word
  logic [15:0] live_errors;                 // live link error word
  logic [15:0] snap_link;                   // held data-link word
  logic [15:0] snap_in_terms;               // held input word
  logic [15:0] snap_drive;                  // held drive word
  logic [15:0] snap_out_terms;              // held output word
  logic [15:0] snap_errors;                 // held error word
  dmsr_pkg::dmsr_monitor_t snap_mon;        // held measurement values
  logic [15:0] read_word;                   // selected register value
  logic        read_miss;                   // register number unmapped

  // set wins over clear so no event is lost in the clearing cycle
  function automatic logic [5:0] sticky_next(input logic [5:0] cur,
                                             input logic [5:0] set,
                                             input logic       clr);
    sticky_next = (clr ? 6'h00 : cur) | set;
  endfunction

  // terminal pins come from outside, so they pass two flops first
  dmsr_pin_sync u_pin_sync (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .pins_in    ({output_terms_in, input_terms_in}),
    .pins_out   (pins_sync)
  );

  // latched link error detail flags
  always_comb begin
    next_err_sticky = sticky_next(err_sticky, link_err_in,
                                  error_reset_in);
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      err_sticky <= dmsr_pkg::ERR_RESET;
    end else begin
      err_sticky <= next_err_sticky;
    end
  end

  // time-out flag for the drive word, cleared with the detail flags
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      timeout_seen <= 1'b0;
    end else if (link_err_in.timeout) begin
      timeout_seen <= 1'b1;
    end else if (error_reset_in) begin
      timeout_seen <= 1'b0;
    end
  end

  // compose live status words; unused bits stay zero
  always_comb begin
    live_link = 16'h0000;
    live_link[dmsr_pkg::LINK_BUSY_BIT]      = write_busy_in;
    live_link[dmsr_pkg::LINK_LIMIT_BIT]     = limit_err_in;
    live_link[dmsr_pkg::LINK_INTEGRITY_BIT] = integrity_err_in;

    live_in_terms = 16'h0000;
    live_in_terms[dmsr_pkg::IN_TERMS-1:0] =
      pins_sync[dmsr_pkg::IN_TERMS-1:0];

    live_out_terms = 16'h0000;
    live_out_terms[dmsr_pkg::OUT_TERMS-1:0] =
      pins_sync[dmsr_pkg::SYNC_W-1:dmsr_pkg::IN_TERMS];

    live_errors = 16'h0000;
    live_errors[dmsr_pkg::ERR_CRC_BIT]     = err_sticky[0];
    live_errors[dmsr_pkg::ERR_LENGTH_BIT]  = err_sticky[1];
    live_errors[dmsr_pkg::ERR_PARITY_BIT]  = err_sticky[2];
    live_errors[dmsr_pkg::ERR_OVERRUN_BIT] = err_sticky[3];
    live_errors[dmsr_pkg::ERR_FRAMING_BIT] = err_sticky[4];
    live_errors[dmsr_pkg::ERR_TIMEOUT_BIT] = err_sticky[5];
  end

  // drive condition word from control flags and the frequency compare
  always_comb begin
    live_drive = 16'h0000;
    live_drive[dmsr_pkg::DRV_RUNNING_BIT]    = drive_flags_in.running;
    live_drive[dmsr_pkg::DRV_ZERO_SPD_BIT]   = drive_flags_in.zero_speed;
    live_drive[dmsr_pkg::DRV_FREQ_MATCH_BIT] = drive_flags_in.freq_match;
    live_drive[dmsr_pkg::DRV_USER_SPD_BIT]   =
      drive_flags_in.user_speed_match;
    // both bits read one when the frequency equals the level
    live_drive[dmsr_pkg::DRV_FDET_LE_BIT]    =
      (monitor_in.out_freq <= freq_level_in);
    live_drive[dmsr_pkg::DRV_FDET_GE_BIT]    =
      (monitor_in.out_freq >= freq_level_in);
    live_drive[dmsr_pkg::DRV_STARTUP_BIT]    = drive_flags_in.startup_done;
    live_drive[dmsr_pkg::DRV_LOW_VOLT_BIT]   =
      drive_flags_in.low_voltage;
    live_drive[dmsr_pkg::DRV_BASEBLOCK_BIT]  = drive_flags_in.baseblock;
    live_drive[dmsr_pkg::DRV_REF_SRC_BIT]    =
      drive_flags_in.ref_not_link;
    live_drive[dmsr_pkg::DRV_RUN_SRC_BIT]    =
      drive_flags_in.run_not_link;
    live_drive[dmsr_pkg::DRV_OVERTORQ_BIT]   = drive_flags_in.overtorque;
    live_drive[dmsr_pkg::DRV_REF_LOST_BIT]   = drive_flags_in.ref_lost;
    live_drive[dmsr_pkg::DRV_RETRY_BIT]      = drive_flags_in.retrying;
    live_drive[dmsr_pkg::DRV_FAULT_BIT]      =
      drive_flags_in.fault | timeout_seen;
    live_drive[dmsr_pkg::DRV_TIMEOUT_BIT]    = timeout_seen;
  end

  // snapshot follows live values, frozen while a read frame runs
  // so a multi-word read sees one coherent sample
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      snap_link      <= dmsr_pkg::WORD_RESET;
      snap_in_terms  <= dmsr_pkg::WORD_RESET;
      snap_drive     <= dmsr_pkg::WORD_RESET;
      snap_out_terms <= dmsr_pkg::WORD_RESET;
      snap_errors    <= dmsr_pkg::WORD_RESET;
      snap_mon       <= '0;
    end else if (!frame_active_in) begin
      snap_link      <= live_link;
      snap_in_terms  <= live_in_terms;
      snap_drive     <= live_drive;
      snap_out_terms <= live_out_terms;
      snap_errors    <= live_errors;
      snap_mon       <= monitor_in;
    end
  end

  // register number decode; gaps answer as unmapped
  always_comb begin
    read_word = 16'h0000;
    read_miss = 1'b0;
    unique case (addr_in)
      dmsr_pkg::ADDR_LINK_STATUS:  read_word = snap_link;
      dmsr_pkg::ADDR_FREQ_REF:     read_word = snap_mon.freq_ref;
      dmsr_pkg::ADDR_OUT_FREQ:     read_word = snap_mon.out_freq;
      dmsr_pkg::ADDR_OUT_VOLT:     read_word = snap_mon.out_volt;
      dmsr_pkg::ADDR_OUT_CURR:     read_word = snap_mon.out_curr;
      dmsr_pkg::ADDR_OUT_POWER:    read_word = snap_mon.out_power;
      dmsr_pkg::ADDR_TORQUE_REF:   read_word = snap_mon.torque_ref;
      dmsr_pkg::ADDR_INPUT_TERMS:  read_word = snap_in_terms;
      dmsr_pkg::ADDR_DRIVE_FLAGS:  read_word = snap_drive;
      dmsr_pkg::ADDR_OUTPUT_TERMS: read_word = snap_out_terms;
      dmsr_pkg::ADDR_DC_BUS:       read_word = snap_mon.dc_bus;
      dmsr_pkg::ADDR_PID_FB:       read_word = snap_mon.pid_fb;
      dmsr_pkg::ADDR_PID_IN:       read_word = snap_mon.pid_in;
      dmsr_pkg::ADDR_PID_OUT:      read_word = snap_mon.pid_out;
      dmsr_pkg::ADDR_MAIN_FW:      read_word = snap_mon.main_fw;
      dmsr_pkg::ADDR_FLASH_FW:     read_word = snap_mon.flash_fw;
      dmsr_pkg::ADDR_LINK_ERRORS:  read_word = snap_errors;
      // unused numbers read zero and flag the miss
      default: begin
        read_miss = 1'b1;
      end
    endcase
  end

  // one answer per strobe; a write always wins and is refused
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rsp_valid_out <= 1'b0;
      rsp_err_out   <= 1'b0;
      rdata_out     <= dmsr_pkg::WORD_RESET;
    end else if (wr_req_in) begin
      rsp_valid_out <= 1'b1;
      rsp_err_out   <= 1'b1;
      rdata_out     <= dmsr_pkg::WORD_RESET;
    end else if (rd_req_in) begin
      rsp_valid_out <= 1'b1;
      rsp_err_out   <= read_miss;
      rdata_out     <= read_word;
    end else begin
      rsp_valid_out <= 1'b0;
      rsp_err_out   <= 1'b0;
    end
  end

  // checks on the answers and the held state
  sequence seq_read(logic [15:0] a);
    rd_req_in && !wr_req_in && addr_in == a;
  endsequence

  sequence seq_frame_held;
    frame_active_in [*2];
  endsequence

  chk_link_unused: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    seq_read(dmsr_pkg::ADDR_LINK_STATUS) |=>
      rsp_valid_out && !rsp_err_out && (rdata_out & 16'hffe6) == 16'h0000)
    else $error("link status unused bits not zero");

  chk_input_terms: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    seq_read(dmsr_pkg::ADDR_INPUT_TERMS) |=> rdata_out[15:7] == 9'h000)
    else $error("input terminal word upper bits not zero");

  chk_freq_detect: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    seq_read(dmsr_pkg::ADDR_DRIVE_FLAGS) |=>
      (rdata_out[dmsr_pkg::DRV_FDET_LE_BIT] ||
       rdata_out[dmsr_pkg::DRV_FDET_GE_BIT]))
    else $error("frequency detection bits both clear");

  chk_fault_timeout: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    seq_read(dmsr_pkg::ADDR_DRIVE_FLAGS) ##1
      rdata_out[dmsr_pkg::DRV_TIMEOUT_BIT] |->
      rdata_out[dmsr_pkg::DRV_FAULT_BIT])
    else $error("time-out shown without fault bit");

  chk_timeout_latch: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    link_err_in.timeout |=> timeout_seen [*2] or
      (timeout_seen ##1 $past(error_reset_in)))
    else $error("time-out flag not latched");

  chk_output_terms: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    seq_read(dmsr_pkg::ADDR_OUTPUT_TERMS) |=> rdata_out[15:3] == 13'h0000)
    else $error("output terminal word upper bits not zero");

  chk_write_reject: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    wr_req_in |=> rsp_valid_out && rsp_err_out && rdata_out == 16'h0000)
    else $error("write to monitor register not refused");

  chk_sticky_hold: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    !error_reset_in |=> (err_sticky & $past(err_sticky)) ==
      $past(err_sticky))
    else $error("link error flag dropped without reset");

  chk_error_clear: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    error_reset_in |=> err_sticky == $past(link_err_in))
    else $error("error reset did not clear or lost an event");

  chk_unmapped_zero: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    seq_read(16'h0029) |=> rsp_err_out && rdata_out == 16'h0000)
    else $error("unused register not answered as zero miss");

  chk_snapshot_hold: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    seq_frame_held |-> $stable(snap_drive) && $stable(snap_mon) &&
      $stable(snap_errors))
    else $error("snapshot changed inside a read frame");

  // snapshot must carry the level compare of the previous edge
  chk_level_compare: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    !frame_active_in |=>
      snap_drive[dmsr_pkg::DRV_FDET_LE_BIT] ==
        ($past(monitor_in.out_freq) <= $past(freq_level_in)) &&
      snap_drive[dmsr_pkg::DRV_FDET_GE_BIT] ==
        ($past(monitor_in.out_freq) >= $past(freq_level_in)))
    else $error("frequency detection bits disagree with level");

  // low voltage level copied straight into the held word
  chk_low_voltage: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    !frame_active_in |=>
      snap_drive[dmsr_pkg::DRV_LOW_VOLT_BIT] ==
        $past(drive_flags_in.low_voltage))
    else $error("low voltage bit not copied from drive flags");

  // source bits keep their polarity: zero means the serial link
  chk_source_bits: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    !frame_active_in |=>
      snap_drive[dmsr_pkg::DRV_REF_SRC_BIT] ==
        $past(drive_flags_in.ref_not_link) &&
      snap_drive[dmsr_pkg::DRV_RUN_SRC_BIT] ==
        $past(drive_flags_in.run_not_link))
    else $error("source bits not copied from drive flags");

endmodule

// File: sim/dmsr_plc_model.sv
// serial master stand-in driving the register port strobes
`timescale 1ns/1ps
module dmsr_plc_model (
  input  wire logic        clk_in,     // system clock
  output logic             rd_req_out, // read strobe
  output logic             wr_req_out, // write strobe
  output logic [15:0]      addr_out    // register number
);
  // idle until the bench asks for an access
  initial begin
    rd_req_out = 1'b0;
    wr_req_out = 1'b0;
    addr_out = 16'h0000;
  end
  // one strobe per access; a released address shows its inverse
  // so a stale number never looks valid by accident
  task automatic access(input logic w, input logic [15:0] a);
    @(posedge clk_in);
    rd_req_out <= ~w;
    wr_req_out <= w;
    addr_out <= a;
    @(posedge clk_in);
    rd_req_out <= 1'b0;
    wr_req_out <= 1'b0;
    addr_out <= ~a;
  endtask
endmodule

// File: sim/tb_top.sv
// self-checking bench for the monitor status register bank
`timescale 1ns/1ps
module tb_top;
  logic                        sys_clk_in = 1'b0; // 50 MHz clock
  logic                        reset_in = 1'b1;   // sync reset
  logic [6:0]                  in_t = '0;         // input pins
  logic [2:0]                  out_t = '0;        // output pins
  dmsr_pkg::dmsr_drive_flags_t flg = '0;          // drive levels
  dmsr_pkg::dmsr_monitor_t     mon = '0;          // mirrored values
  logic [15:0]                 lvl = '0;          // detection level
  logic [2:0]                  lnk = '0;          // busy, limit, integrity
  dmsr_pkg::dmsr_link_err_t    lerr = '0;         // error pulses
  logic                        erst = 1'b0;       // error reset pulse
  logic                        frame = 1'b0;      // snapshot freeze
  logic                        rd_stb, wr_stb;    // strobes from model
  logic [15:0]                 addr;              // register number
  logic                        vld, rerr;         // answer and refusal
  logic [15:0]                 rdata;             // read data
  logic [16:0]                 exp_q[$];          // expected answers
  logic [15:0]                 seed = 16'h004b;   // random state
  logic [15:0]                 old;               // frozen value
  int                          n_fail = 0;        // mismatches
  int                          comparisons = 0;   // compares made
  int                          cycles = 0;        // hang guard
  logic [15:0] maddr [12] = '{16'h0023, 16'h0024, 16'h0025, 16'h0026,
    16'h0027, 16'h0028, 16'h0031, 16'h0038, 16'h0039, 16'h003a,
    16'h003b, 16'h003c};                          // mirror numbers

  always #10 sys_clk_in = ~sys_clk_in;

  dmsr_bank i_dmsr_bank (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .input_terms_in(in_t), .output_terms_in(out_t),
    .drive_flags_in(flg), .monitor_in(mon), .freq_level_in(lvl),
    .write_busy_in(lnk[0]), .limit_err_in(lnk[1]),
    .integrity_err_in(lnk[2]), .link_err_in(lerr),
    .error_reset_in(erst), .frame_active_in(frame), .rd_req_in(rd_stb),
    .wr_req_in(wr_stb), .addr_in(addr), .rsp_valid_out(vld),
    .rsp_err_out(rerr), .rdata_out(rdata));
  dmsr_plc_model i_dmsr_plc_model (.clk_in(sys_clk_in),
    .rd_req_out(rd_stb), .wr_req_out(wr_stb), .addr_out(addr));

  // galois-free shift register, taps 16,14,13,11
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  // expected drive condition word; t is the latched time-out
  function automatic logic [15:0] dw(input logic [12:0] f,
    input logic [15:0] q, input logic [15:0] l, input logic t);
    return {t, f[0] | t, f[1], f[2], f[3], f[4], f[5], f[6], f[7], f[8],
      q >= l, q <= l, f[9], f[10], f[11], f[12]};
  endfunction
  // expected error detail word, bit 2 and the top unused
  function automatic logic [16:0] em(input logic [5:0] e);
    return {10'h000, e[5:2], 1'b0, e[1:0]};
  endfunction

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  // note the expected answer, then let the master ask
  task automatic rd(input logic [15:0] a, input logic [16:0] e);
    exp_q.push_back(e);
    i_dmsr_plc_model.access(1'b0, a);
  endtask
  task automatic wrt(input logic [15:0] a);
    exp_q.push_back(17'h10000);
    i_dmsr_plc_model.access(1'b1, a);
  endtask
  // one error pulse with optional reset, then let it settle
  task automatic pulse(input logic [5:0] e, input logic c);
    @(posedge sys_clk_in);
    lerr <= e;
    erst <= c;
    @(posedge sys_clk_in);
    lerr <= '0;
    erst <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
  endtask
  task automatic summarize();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watcher: each answer takes the oldest note
  always @(negedge sys_clk_in) begin
    if (vld === 1'b1) begin
      if (exp_q.size() == 0)
        check({rerr, rdata}, 17'bx);
      else
        check({rerr, rdata}, exp_q.pop_front());
    end
  end
  // hang guard, far above the few hundred cycles used
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    repeat (10) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    // zero frequency against a zero level sets both detection bits
    rd(16'h002c, {1'b0, dw(flg, mon[175:160], lvl, 1'b0)});
    // level below, equal to and above the output frequency
    for (int r = 0; r < 3; r++) begin
      @(posedge sys_clk_in);
      for (int j = 0; j < 12; j++)
        mon[16*j +: 16] <= rnd();
      flg <= 13'(rnd());
      {in_t, out_t, lnk} <= 13'(rnd());
      @(posedge sys_clk_in);
      lvl <= mon[175:160] + 16'(r) - 16'h0001;
      repeat (4) @(posedge sys_clk_in);
      rd(16'h0022, {11'h0, lnk[2:1], 2'b00, lnk[0]});
      rd(16'h002b, {10'h0, in_t});
      rd(16'h002c, {1'b0, dw(flg, mon[175:160], lvl, 1'b0)});
      rd(16'h002d, {14'h0, out_t});
      for (int j = 0; j < 12; j++)
        rd(maddr[j], {1'b0, mon[191-16*j -: 16]});
    end
    // every error kind latches, time-out also flags the drive word
    for (int i = 0; i < 6; i++) begin
      pulse(6'h01 << i, 1'b0);
      rd(16'h003d, em(6'h01 << i));
      wrt(16'h003d);
      rd(16'h003d, em(6'h01 << i));
      if (i == 5)
        rd(16'h002c, {1'b0, dw(flg, mon[175:160], lvl, 1'b1)});
      pulse(6'h00, 1'b1);
      rd(16'h003d, 17'h0);
    end
    pulse(6'h01, 1'b1);
    rd(16'h003d, em(6'h01));
    pulse(6'h00, 1'b1);
    rd(16'h0029, 17'h10000);
    rd(16'h003e, 17'h10000);
    wrt(16'h002c);
    // snapshot holds while a frame is active
    @(posedge sys_clk_in);
    frame <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    old = mon[175:160];
    mon[175:160] <= ~old;
    repeat (4) @(posedge sys_clk_in);
    rd(16'h0024, {1'b0, old});
    @(posedge sys_clk_in);
    frame <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    rd(16'h0024, {1'b0, ~old});
    repeat (4) @(posedge sys_clk_in);
    check(17'(exp_q.size()), 17'h0);
    summarize();
  end
endmodule
